// ---- mtc_defs.svh ----
// constants of the transceiver mode control and configuration port
`ifndef MTC_DEFS_SVH
`define MTC_DEFS_SVH
// command byte field positions
`define MTC_CMD_CNT_MSB 7
`define MTC_CMD_CNT_LSB 6
`define MTC_CMD_ADDR_MSB 5
`define MTC_CMD_ADDR_LSB 1
`define MTC_CMD_RW_BIT 0
`define MTC_RW_WRITE 1'b1
// serial framing
`define MTC_LAST_BIT 3'h7
`define MTC_NUM_REGS 32
// modulation select encodings
`define MTC_MOD_OOK 1'b0
`define MTC_MOD_FSK 1'b1
// documented state numbers
`define MTC_NUM_CFG 7'h01
`define MTC_NUM_LVD 7'h05
`define MTC_NUM_RX 7'h14
`define MTC_NUM_TX 7'h1e
`define MTC_NUM_STBY 7'h3c
// reset values
`define MTC_RST_STATE_NUM 7'h3c
`define MTC_RST_CNT 4'h0
`endif

// ---- mtc_pkg.sv ----
// types shared by the mode control and configuration port
package mtc_pkg;
  // one-hot operating modes
  typedef enum logic [4:0] {
    MTC_S_STBY = 5'b00001,
    MTC_S_LVD = 5'b00010,
    MTC_S_CFG = 5'b00100,
    MTC_S_TX = 5'b01000,
    MTC_S_RX = 5'b10000
  } mtc_state_t;
  // pins that cross into the reference clock domain together
  typedef struct packed {
    logic config_select_n;
    logic strobe;
    logic serial_enable_n;
    logic mosi;
    logic pll_lock;
  } mtc_pins_t;
  // one register write handed from the serial side to the core
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] data;
  } mtc_wr_t;
endpackage

// ---- mtc_port.sv ----
// mode control, transmit keying and serial configuration port
`timescale 1ns/1ps
`include "mtc_defs.svh"

// Contract
// - on-off keying: output stage on while serial input is 1, off at 0.
// - frequency shift: carrier at logical-one frequency for 1, zero for 0.
// - transmit is single state 30, serial input passed straight to modulator.
// - transmit only while pll locked; lock loss switches output stage off.
// - standby on select high, strobe low; everything ignored until exit; code still takes serial traffic in standby while select is low.
// - standby is state 60 without detect enable, states 5 and 20 with it; code shows state 5 only.
// - standby left only by select low and strobe high, into configuration.
// - in configuration the host drives clock and input, device drives output.
// - transfers are bytes; only first byte after select fall is a command.
// - count field 00,01,10,11 means 1,2,4,8 registers accessed.
// - command bits 5:1 give start address, advanced by count per byte.
// - command bit 0 low reads onto output line, high writes from input.
// - byte taken on eighth falling clock edge; partial bits dropped.
// - entering configuration by pin levels keeps register contents.
// - configuration is state 1, no traffic, rf stages keep previous state.
// - automatic bank switching only in receive; transmit bank set directly.
module mtc_port (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_sclk,
  input wire logic i_config_select_n,
  input wire logic i_serial_enable_n,
  input wire logic i_strobe,
  input wire logic i_mosi,
  input wire logic i_pll_lock,
  input wire logic i_modulation_select,
  input wire logic i_low_voltage_detect_enable,
  input wire logic i_transmit_config,
  input wire logic i_bank_auto_req,
  output logic o_miso,
  output logic o_miso_oe_n,
  output logic o_rf_on,
  output logic o_carrier_one,
  output logic [6:0] o_state_num,
  output logic o_config_mode,
  output logic o_supply_monitor_mode,
  output logic o_bank_auto_en,
  output logic o_cfg_wr_stb,
  output mtc_pkg::mtc_wr_t o_cfg_wr
);

  // count field to number of registers, one-hot power of two
  function automatic logic [3:0] count_dec(input logic [1:0] f);
    count_dec = 4'h1 << f;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // serial side, clocked by the host's serial clock
  ////////////////////////////////////////////////////////////////////////

  logic [7:0] regs_q [`MTC_NUM_REGS];
  logic link_rst, first_q, rw_q, miso_oe_n_q, wr_tgl_q;
  logic [2:0] bit_cnt_q;
  logic [6:0] sh_q;
  logic [4:0] addr_q;
  logic [3:0] n_q, left_q;
  logic [7:0] tx_q;
  mtc_pkg::mtc_wr_t wr_hold_q;
  wire [7:0] rx_byte;
  wire [4:0] addr_next, cmd_addr;
  wire byte_done, data_byte, do_write;

  // the frame is held in reset whenever the port is deselected, so the
  // first byte after a select fall is always taken as a command
  assign link_rst = i_config_select_n | i_serial_enable_n;
  assign rx_byte = {sh_q, i_mosi};
  assign byte_done = (bit_cnt_q == `MTC_LAST_BIT);
  assign data_byte = byte_done && !first_q && (left_q != `MTC_RST_CNT);
  assign addr_next = addr_q + {1'b0, n_q};
  assign cmd_addr = rx_byte[`MTC_CMD_ADDR_MSB:`MTC_CMD_ADDR_LSB];
  assign do_write = data_byte && (rw_q == `MTC_RW_WRITE);

  // bit counter and command decode; a partial byte never reaches a store
  always_ff @(negedge i_sclk or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt_q <= 3'h0;
      first_q <= 1'b1;
      sh_q <= 7'h00;
      addr_q <= 5'h00;
      n_q <= `MTC_RST_CNT;
      left_q <= `MTC_RST_CNT;
      rw_q <= 1'b0;
    end else begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      sh_q <= rx_byte[6:0];
      if (byte_done && first_q) begin
        first_q <= 1'b0;
        addr_q <= cmd_addr;
        n_q <= count_dec(rx_byte[`MTC_CMD_CNT_MSB:`MTC_CMD_CNT_LSB]);
        left_q <= count_dec(rx_byte[`MTC_CMD_CNT_MSB:`MTC_CMD_CNT_LSB]);
        rw_q <= rx_byte[`MTC_CMD_RW_BIT];
      end else if (data_byte) begin
        addr_q <= addr_next;
        left_q <= left_q - 4'h1;
      end
    end
  end

  // read data shifter; msb shows right after the loading edge so the host
  // can sample it on the following rising edge
  always_ff @(negedge i_sclk or posedge link_rst) begin
    if (link_rst) begin
      tx_q <= 8'h00;
      miso_oe_n_q <= 1'b1;
    end else if (byte_done && first_q && !rx_byte[`MTC_CMD_RW_BIT]) begin
      tx_q <= regs_q[cmd_addr];
      miso_oe_n_q <= 1'b0;
    end else if (data_byte && !rw_q && left_q != 4'h1) begin
      tx_q <= regs_q[addr_next];
    end else begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  // register storage has no reset: select and strobe levels alone never
  // change it, only a completed write byte does
  always_ff @(negedge i_sclk) begin
    if (do_write) begin
      regs_q[addr_q] <= rx_byte;
    end
  end

  // write event for the core: hold word plus toggle; the next write is at
  // least eight serial clocks away, far longer than the synchroniser
  always_ff @(negedge i_sclk or posedge i_reset) begin
    if (i_reset) begin
      wr_tgl_q <= 1'b0;
      wr_hold_q <= '0;
    end else if (do_write) begin
      wr_tgl_q <= ~wr_tgl_q;
      wr_hold_q <= '{addr: addr_q, data: rx_byte};
    end
  end

  assign o_miso = tx_q[7];
  assign o_miso_oe_n = miso_oe_n_q;

  ////////////////////////////////////////////////////////////////////////
  // reference clock side: pin synchronisers and mode control
  ////////////////////////////////////////////////////////////////////////

  mtc_pkg::mtc_pins_t pins_raw, pin_s1_q, pin_s2_q;
  logic tgl_s1_q, tgl_s2_q, tgl_s3_q;
  mtc_pkg::mtc_state_t state_q, state_d, idle_st;
  logic rf_on_q, carrier_one_q, cfg_mode_q, smon_q, bank_auto_q, wr_stb_q;
  logic [6:0] state_num_q;
  mtc_pkg::mtc_wr_t cfg_wr_q;
  wire is_tx, is_idle, cfg_req, stby_req, ook_on, rf_on_d, carrier_d;
  wire [6:0] state_num_d;

  assign pins_raw = '{config_select_n: i_config_select_n,
                      strobe: i_strobe,
                      serial_enable_n: i_serial_enable_n,
                      mosi: i_mosi,
                      pll_lock: i_pll_lock};

  // two flops before any logic looks at a pin of pins_raw
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
    end else begin
      pin_s1_q <= pins_raw;
      pin_s2_q <= pin_s1_q;
      tgl_s1_q <= wr_tgl_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
    end
  end

  // mode requests decoded from synchronised pin levels
  assign cfg_req = !pin_s2_q.config_select_n && pin_s2_q.strobe;
  assign stby_req = pin_s2_q.config_select_n && !pin_s2_q.strobe;
  assign is_idle = (state_q == mtc_pkg::MTC_S_STBY) ||
                   (state_q == mtc_pkg::MTC_S_LVD);
  assign is_tx = (state_q == mtc_pkg::MTC_S_TX);
  assign idle_st = i_low_voltage_detect_enable ?
                   mtc_pkg::MTC_S_LVD : mtc_pkg::MTC_S_STBY;

  // next mode; no serial traffic moves the state out of standby, and only a configuration
  // request gets it out
  always_comb begin
    state_d = state_q;
    case (state_q)
      mtc_pkg::MTC_S_STBY, mtc_pkg::MTC_S_LVD: begin
        state_d = cfg_req ? mtc_pkg::MTC_S_CFG : idle_st;
      end
      mtc_pkg::MTC_S_CFG: begin
        if (pin_s2_q.config_select_n) begin
          if (!pin_s2_q.strobe) begin
            state_d = idle_st;
          end else if (i_transmit_config) begin
            state_d = mtc_pkg::MTC_S_TX;
          end else begin
            state_d = mtc_pkg::MTC_S_RX;
          end
        end
      end
      mtc_pkg::MTC_S_TX, mtc_pkg::MTC_S_RX: begin
        if (!pin_s2_q.config_select_n) begin
          state_d = mtc_pkg::MTC_S_CFG;
        end else if (stby_req) begin
          state_d = idle_st;
        end
      end
      default: begin
        state_d = mtc_pkg::MTC_S_STBY;
      end
    endcase
  end

  // keying straight from the serial input; configuration keeps the stage
  // as it was, but a lost lock always wins so nothing leaves off band
  assign ook_on = (i_modulation_select == `MTC_MOD_FSK) || pin_s2_q.mosi;
  assign rf_on_d = pin_s2_q.pll_lock &&
                   (is_tx ? ook_on :
                    (state_q == mtc_pkg::MTC_S_CFG) && rf_on_q);
  assign carrier_d = is_tx ?
                     (i_modulation_select == `MTC_MOD_FSK) && pin_s2_q.mosi :
                     carrier_one_q;

  // documented state numbers shown to the outside
  assign state_num_d =
    (state_q == mtc_pkg::MTC_S_CFG) ? `MTC_NUM_CFG :
    (state_q == mtc_pkg::MTC_S_TX) ? `MTC_NUM_TX :
    (state_q == mtc_pkg::MTC_S_RX) ? `MTC_NUM_RX :
    (state_q == mtc_pkg::MTC_S_LVD) ? `MTC_NUM_LVD : `MTC_NUM_STBY;

  // mode register
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state_q <= mtc_pkg::MTC_S_STBY;
    end else begin
      state_q <= state_d;
    end
  end

  // output flops, all updated every cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      rf_on_q <= 1'b0;
      carrier_one_q <= 1'b0;
      state_num_q <= `MTC_RST_STATE_NUM;
      cfg_mode_q <= 1'b0;
      smon_q <= 1'b0;
      bank_auto_q <= 1'b0;
    end else begin
      rf_on_q <= rf_on_d;
      carrier_one_q <= carrier_d;
      state_num_q <= state_num_d;
      cfg_mode_q <= (state_q == mtc_pkg::MTC_S_CFG);
      smon_q <= (state_q == mtc_pkg::MTC_S_LVD);
      bank_auto_q <= (state_q == mtc_pkg::MTC_S_RX) &&
                     i_bank_auto_req;
    end
  end

  // write event handed over: the hold word is stable when the toggle
  // edge is seen, so it is captured without its own synchroniser
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      wr_stb_q <= 1'b0;
      cfg_wr_q <= '0;
    end else begin
      wr_stb_q <= tgl_s2_q ^ tgl_s3_q;
      if (tgl_s2_q ^ tgl_s3_q) begin
        cfg_wr_q <= wr_hold_q;
      end
    end
  end

  assign o_rf_on = rf_on_q;
  assign o_carrier_one = carrier_one_q;
  assign o_state_num = state_num_q;
  assign o_config_mode = cfg_mode_q;
  assign o_supply_monitor_mode = smon_q;
  assign o_bank_auto_en = bank_auto_q;
  assign o_cfg_wr_stb = wr_stb_q;
  assign o_cfg_wr = cfg_wr_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  ////////////////////////////////////////////////////////////////////////

  sequence seq_in_standby;
    is_idle;
  endsequence

  sequence seq_no_cfg_req;
    !cfg_req;
  endsequence

  chk_ook_keying: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    (is_tx && i_modulation_select == `MTC_MOD_OOK && pin_s2_q.pll_lock)
    |=> (o_rf_on == $past(pin_s2_q.mosi)))
    else $error("ook stage does not follow serial input");

  chk_fsk_carrier: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    (is_tx && i_modulation_select == `MTC_MOD_FSK && pin_s2_q.pll_lock)
    |=> (o_carrier_one == $past(pin_s2_q.mosi)) && o_rf_on)
    else $error("fsk carrier does not follow serial input");

  chk_tx_state_num: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    is_tx |=> (o_state_num == 7'h1e))
    else $error("transmit state number wrong");

  chk_lock_loss_off: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    !pin_s2_q.pll_lock |=> !o_rf_on)
    else $error("output stage on without pll lock");

  chk_standby_holds: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    seq_in_standby ##0 seq_no_cfg_req |=> seq_in_standby)
    else $error("standby left without configuration request");

  chk_standby_number: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    (state_q == mtc_pkg::MTC_S_STBY) |=>
    (o_state_num == 7'h3c) && !o_supply_monitor_mode)
    else $error("standby number or monitor flag wrong");

  chk_standby_exit: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    seq_in_standby ##1 !is_idle |-> (state_q == mtc_pkg::MTC_S_CFG))
    else $error("standby exited to a mode other than configuration");

  chk_cfg_rf_hold: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    (state_q == mtc_pkg::MTC_S_CFG && pin_s2_q.pll_lock) |=>
    $stable(o_rf_on) && (o_state_num == 7'h01))
    else $error("rf stage changed during configuration");

  chk_bank_auto_rx: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    o_bank_auto_en |-> ($past(state_q) == mtc_pkg::MTC_S_RX))
    else $error("bank switching enabled outside receive");

  chk_cmd_count: assert property (
    @(negedge i_sclk) disable iff (link_rst)
    (byte_done && first_q && rx_byte[7:6] == 2'b11) |=>
    (n_q == 4'h8) && (left_q == 4'h8))
    else $error("count field 11 not decoded as eight");

  chk_addr_step: assert property (
    @(negedge i_sclk) disable iff (link_rst)
    data_byte |=> (addr_q == 5'($past(addr_q) + {1'b0, $past(n_q)})))
    else $error("address not advanced by count");

endmodule

// ---- mtc_host_model.sv ----
// host controller model driving the serial and mode pins of the port
`timescale 1ns/1ps

module mtc_host #(
  parameter int HALF_NS = 80,
  parameter int STARTUP_NS = 400
) (
  input wire logic i_miso,
  output logic o_sclk,
  output logic o_config_select_n,
  output logic o_serial_enable_n,
  output logic o_strobe,
  output logic o_mosi
);
  ////////////////////////////////////////////////////////////////////////
  // idle levels: clock parked low outside frames, port deselected
  initial begin
    o_sclk = 1'b0;
    o_config_select_n = 1'b1;
    o_serial_enable_n = 1'b1;
    o_strobe = 1'b0;
    o_mosi = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // mode pins; the wait covers oscillator plus pll lock before any access
  task automatic set_mode(input logic sel_n, input logic stb);
    o_config_select_n = sel_n;
    o_serial_enable_n = sel_n;
    o_strobe = stb;
    #(STARTUP_NS);
  endtask

  // level on the data line while transmitting
  task automatic key(input logic v);
    o_mosi = v;
  endtask

  // one unit, msb first; mosi moves on the rising edge so it is settled
  // at the falling edge that takes it, miso taken on the rising edge
  task automatic xfer(input logic [7:0] tx, input int nbits,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      #(HALF_NS);
      o_sclk = 1'b1;
      rx[i] = i_miso;
      o_mosi = tx[i];
      #(HALF_NS);
      o_sclk = 1'b0;
    end
    #(HALF_NS);
  endtask

  // restart receive: short select low resets the sequencer, then high
  task automatic rx_restart(input int low_ns, input int id_ns);
    o_config_select_n = 1'b0;
    #(low_ns);
    o_config_select_n = 1'b1;
    #(id_ns);
  endtask

  // select pulse between accesses; released data line must not hold
  task automatic frame_end();
    #(HALF_NS);
    o_config_select_n = 1'b1;
    o_mosi = ~o_mosi;
    #(HALF_NS);
    o_config_select_n = 1'b0;
  endtask
endmodule

// ---- tb.sv ----
// self-checking bench for the mode control and configuration port
`timescale 1ns/1ps

`define CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("mismatch t=%0t got=%0h exp=%0h", $time, got, exp); \
    end \
  end

module tb;
  logic clk, rst, sclk, csn, sen, stb, mosi, lock, mod_sel, lvd_en;
  logic tx_cfg, bank_req, miso, miso_oe_n, miso_line, rf_on, carrier_one;
  logic config_mode, supply_mon, bank_auto_en, wr_stb;
  logic [6:0] state_num;
  mtc_pkg::mtc_wr_t wr;
  mtc_pkg::mtc_wr_t wq[$];
  int fail_count = 0;
  int comparisons = 0;

  mtc_port uut (.i_ref_clk(clk), .i_reset(rst), .i_sclk(sclk),
    .i_config_select_n(csn), .i_serial_enable_n(sen), .i_strobe(stb),
    .i_mosi(mosi), .i_pll_lock(lock), .i_modulation_select(mod_sel),
    .i_low_voltage_detect_enable(lvd_en), .i_transmit_config(tx_cfg),
    .i_bank_auto_req(bank_req), .o_miso(miso), .o_miso_oe_n(miso_oe_n),
    .o_rf_on(rf_on), .o_carrier_one(carrier_one), .o_state_num(state_num),
    .o_config_mode(config_mode), .o_supply_monitor_mode(supply_mon),
    .o_bank_auto_en(bank_auto_en), .o_cfg_wr_stb(wr_stb), .o_cfg_wr(wr));

  mtc_host host (.i_miso(miso_line), .o_sclk(sclk),
    .o_config_select_n(csn), .o_serial_enable_n(sen), .o_strobe(stb),
    .o_mosi(mosi));

  // undriven line toggles so a stale bit never reads as valid
  assign miso_line = (miso_oe_n === 1'b0) ? miso : ~sclk;

  ////////////////////////////////////////////////////////////////////////
  // clock, reset and write capture
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // taken mid-cycle, where the strobe and word have settled
  always @(negedge clk) begin
    if (wr_stb === 1'b1) wq.push_back(wr);
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // standby refuses a half entry, detect state, then configuration
  task automatic t_standby();
    `CHK(state_num, 7'h3c)
    host.set_mode(1'b0, 1'b0);
    `CHK(state_num, 7'h3c)
    `CHK(config_mode, 1'b0)
    host.set_mode(1'b1, 1'b0);
    lvd_en = 1'b1;
    cyc(8);
    `CHK(state_num, 7'h05)
    `CHK(supply_mon, 1'b1)
    host.set_mode(1'b0, 1'b1);
    lvd_en = 1'b0;
    `CHK(state_num, 7'h01)
    `CHK(config_mode, 1'b1)
  endtask

  // every count code, one surplus byte and trailing bits per frame
  task automatic t_write();
    logic [7:0] rx;
    int n;
    for (int c = 0; c < 4; c++) begin
      n = 1 << c;
      host.xfer({c[1:0], 5'h01, 1'b1}, 8, rx);
      for (int i = 0; i <= n; i++) host.xfer({c[3:0], i[3:0]}, 8, rx);
      host.xfer(8'hff, 3, rx);
      `CHK(miso_oe_n, 1'b1)
      host.frame_end();
      cyc(8);
      `CHK(wq.size(), n)
      for (int i = 0; i < n; i++) begin
        `CHK(wq[i], {5'(1 + i * n), c[3:0], i[3:0]})
      end
      wq.delete();
    end
  endtask

  // four registers read back after re-entries, surplus byte reads 0
  task automatic t_read();
    logic [7:0] rx;
    logic [7:0] exp [5] = '{8'h34, 8'h21, 8'h35, 8'h23, 8'h00};
    host.xfer({2'b10, 5'h01, 1'b0}, 8, rx);
    `CHK(miso_oe_n, 1'b0)
    for (int i = 0; i < 5; i++) begin
      host.xfer(8'h00, 8, rx);
      `CHK(rx, exp[i])
    end
    host.frame_end();
    `CHK(miso_oe_n, 1'b1)
  endtask

  // receive, transmit keying, lock loss, held stage, standby
  task automatic t_tx();
    logic [7:0] rx;
    bank_req = 1'b1;
    host.set_mode(1'b1, 1'b1);
    `CHK(state_num, 7'h14)
    `CHK(bank_auto_en, 1'b1)
    host.rx_restart(8, 400);
    `CHK(state_num, 7'h14)
    host.set_mode(1'b0, 1'b1);
    tx_cfg = 1'b1;
    host.set_mode(1'b1, 1'b1);
    `CHK(state_num, 7'h1e)
    `CHK(bank_auto_en, 1'b0)
    for (int m = 1; m >= 0; m--) begin
      mod_sel = m[0];
      for (int b = 1; b >= 0; b--) begin
        host.key(b[0]);
        cyc(6);
        if (m == 0) `CHK(rf_on, b[0])
        else `CHK(carrier_one, b[0])
      end
    end
    host.key(1'b1);
    cyc(6);
    `CHK(rf_on, 1'b1)
    lock = 1'b0;
    cyc(6);
    `CHK(rf_on, 1'b0)
    lock = 1'b1;
    cyc(6);
    host.set_mode(1'b0, 1'b1);
    `CHK(rf_on, 1'b1)
    host.set_mode(1'b1, 1'b0);
    `CHK(state_num, 7'h3c)
    host.xfer({2'b00, 5'h02, 1'b1}, 8, rx);
    host.xfer(8'h5a, 8, rx);
    cyc(8);
    `CHK(wq.size(), 0)
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst = 1'b1;
    lock = 1'b1;
    mod_sel = 1'b0;
    lvd_en = 1'b0;
    tx_cfg = 1'b0;
    bank_req = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    cyc(2);
    t_standby();
    t_write();
    t_read();
    t_tx();
    test_done();
  end

  // whole run needs well under this span
  initial begin
    #300000;
    fail_count++;
    test_done();
  end
endmodule
